// [src/scl_pkg.sv]
package scl_pkg;

    // Clock and timing
    localparam int    REF_CLK_HZ          = 25_000_000;
    localparam real   RESET_TIMEOUT_US    = 100.0;
    // Longest time rounds to the nearest cycle
    localparam int    RESET_TIMEOUT_CYC   = int'(RESET_TIMEOUT_US
                                                * REF_CLK_HZ / 1.0E6);
    localparam int    INIT_CYCLES         = 299;
    localparam int    SYNC_STAGES         = 2;

    // Default configuration image size in bits
    localparam int    IMAGE_BITS_DEFAULT  = 64;

    typedef enum logic [5:0] {
        SCL_RESET = 6'h01,
        SCL_LOAD  = 6'h02,
        SCL_DONE  = 6'h04,
        SCL_INIT  = 6'h08,
        SCL_USER  = 6'h10,
        SCL_ERROR = 6'h20
    } scl_state_t;

endpackage

// [src/scl_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin levels
module scl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Reset low: lines read as held in reset, no false edges
            meta   <= '0;
            synced <= '0;
        end else begin
            meta   <= async;
            synced <= meta;
        end
    end
endmodule

// [src/scl_config_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - Error: drive status low, reset internally
// - Auto-restart releases status after time-out
// - User mode request low: lines low, tri-state
// - Restart only after request high, status released
// - Loaded device drives chain enable out low
// - Load waits until wired status line released
// - Wired completion: chain initializes together
// - Data error during load pulls shared status low, reload
// - Held in reset while request or status low
// - Data bit sampled on serial clock rise
// - 299 start-up clocks before user mode
module scl_config_ctrl
    import scl_pkg::*;
#(
    parameter int IMAGE_BITS  = IMAGE_BITS_DEFAULT,
    parameter int TIMEOUT_CYC = RESET_TIMEOUT_CYC,
    parameter int INIT_CYC    = INIT_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  autoRestart,
    input  wire logic                  configRequest_n,
    input  wire logic                  statusIn,
    output logic                       statusOut,
    output logic                       statusOe,
    input  wire logic                  confDoneIn,
    output logic                       confDoneOut,
    output logic                       confDoneOe,
    input  wire logic                  chain_enable_in_n,
    output logic                       chain_enable_out_n,
    input  wire logic                  serial_config_clock,
    input  wire logic                  serial_config_data,
    input  wire logic                  user_startup_clock,
    input  wire logic                  dataError,
    output logic                       userMode,
    output logic                       ioTristate,
    output logic [IMAGE_BITS-1:0]      image
);

    // Shift register needs at least two bits
    if (IMAGE_BITS < 2 || TIMEOUT_CYC < 1 || INIT_CYC < 1) begin : g_bad_param
        $error("scl_config_ctrl: bad parameter");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [6:0] pinSync;
    logic       reqN;
    logic       statusHigh;
    logic       doneHigh;
    logic       chainInN;
    logic       dclkS;
    logic       dataS;
    logic       usrClkS;

    scl_sync #(.WIDTH(7)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .async   ({configRequest_n, statusIn, confDoneIn, chain_enable_in_n,
                   serial_config_clock, serial_config_data,
                   user_startup_clock}),
        .synced  (pinSync)
    );

    assign {reqN, statusHigh, doneHigh, chainInN, dclkS, dataS, usrClkS} =
        pinSync;

    logic dclkPrev;
    logic usrPrev;
    logic dclkRise;
    logic usrRise;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dclkPrev <= 1'b0;
            usrPrev  <= 1'b0;
        end else begin
            dclkPrev <= dclkS;
            usrPrev  <= usrClkS;
        end
    end

    assign dclkRise = dclkS & ~dclkPrev;
    assign usrRise  = usrClkS & ~usrPrev;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    scl_state_t state;
    scl_state_t next_state;
    logic [$clog2(IMAGE_BITS+1)-1:0] bitCount;
    logic [$clog2(TIMEOUT_CYC+1)-1:0] toCount;
    logic [$clog2(INIT_CYC+1)-1:0]    initCount;
    logic autoLatched;

    // Option caught on every cycle in SCL_RESET, held static in other states
    always_ff @(posedge ref_clk) begin
        if (rst)
            autoLatched <= 1'b0;
        else if (state == SCL_RESET)
            autoLatched <= autoRestart;
    end

    always_comb begin
        next_state = state;
        case (state)
            SCL_RESET: begin
                if (reqN && statusHigh)
                    next_state = SCL_LOAD;
            end
            SCL_LOAD: begin
                if (!reqN || !statusHigh)
                    next_state = SCL_RESET;
                else if (dataError && !chainInN)
                    next_state = SCL_ERROR;
                else if (bitCount == IMAGE_BITS[$bits(bitCount)-1:0])
                    next_state = SCL_DONE;
            end
            SCL_DONE: begin
                if (!reqN || !statusHigh)
                    next_state = SCL_RESET;
                else if (doneHigh)
                    next_state = SCL_INIT;
            end
            SCL_INIT: begin
                if (!reqN || !statusHigh)
                    next_state = SCL_RESET;
                else if (initCount == INIT_CYC[$bits(initCount)-1:0])
                    next_state = SCL_USER;
            end
            SCL_USER: begin
                if (!reqN)
                    next_state = SCL_RESET;
            end
            SCL_ERROR: begin
                if (!reqN)
                    next_state = SCL_RESET;
                else if (autoLatched &&
                         toCount == TIMEOUT_CYC[$bits(toCount)-1:0])
                    next_state = SCL_RESET;
            end
            default: next_state = SCL_RESET;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            state <= SCL_RESET;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial data capture

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bitCount <= '0;
            image    <= '0;
        end else if (state != SCL_LOAD) begin
            if (state == SCL_RESET)
                bitCount <= '0;
        end else if (dclkRise && !chainInN) begin
            image    <= {image[IMAGE_BITS-2:0], dataS};
            bitCount <= bitCount + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters

    always_ff @(posedge ref_clk) begin
        if (rst || state != SCL_ERROR)
            toCount <= '0;
        else if (toCount != TIMEOUT_CYC[$bits(toCount)-1:0])
            toCount <= toCount + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || state != SCL_INIT)
            initCount <= '0;
        else if (usrRise)
            initCount <= initCount + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Wired pins and outputs

    assign statusOut   = 1'b0;
    assign confDoneOut = 1'b0;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            statusOe           <= 1'b1;
            confDoneOe         <= 1'b1;
            chain_enable_out_n <= 1'b1;
            userMode           <= 1'b0;
            ioTristate         <= 1'b1;
        end else begin
            statusOe   <= (next_state == SCL_ERROR) || !reqN;
            confDoneOe <= (next_state == SCL_RESET) ||
                          (next_state == SCL_LOAD) ||
                          (next_state == SCL_ERROR);
            chain_enable_out_n <= !((next_state == SCL_DONE) ||
                                    (next_state == SCL_INIT) ||
                                    (next_state == SCL_USER));
            userMode   <= (next_state == SCL_USER);
            ioTristate <= (next_state != SCL_USER);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_error_pulls_status: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_ERROR |-> statusOe)
        else $error("status not driven low in error");

    a_timeout_release: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_ERROR && reqN && autoLatched &&
        toCount == TIMEOUT_CYC[$bits(toCount)-1:0]
        |=> state == SCL_RESET)
        else $error("no release after time-out");

    a_no_auto_hold: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_ERROR && reqN && !autoLatched
        |=> state == SCL_ERROR)
        else $error("left error without request");

    a_user_request: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_USER && !reqN
        |=> statusOe && confDoneOe && ioTristate)
        else $error("request in user mode ignored");

    a_load_needs_lines: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_RESET && (!reqN || !statusHigh)
        |=> state == SCL_RESET)
        else $error("load began while held in reset");

    a_status_low_reset: assert property (@(posedge ref_clk) disable iff (rst)
        state inside {SCL_LOAD, SCL_DONE, SCL_INIT} && !statusHigh
        |=> state == SCL_RESET)
        else $error("stayed active while status low");

    a_chain_out: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_DONE |-> !chain_enable_out_n)
        else $error("chain enable out not low when done");

    a_sample_rise: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_LOAD && next_state == SCL_LOAD && dclkRise && !chainInN
        |=> image[0] == $past(dataS))
        else $error("data bit not sampled on rise");

    a_init_count: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_INIT && $past(state) != SCL_INIT
        |-> initCount == '0)
        else $error("init count not cleared");

    a_wait_completion: assert property (@(posedge ref_clk) disable iff (rst)
        state == SCL_DONE && !doneHigh && reqN && statusHigh
        |=> state == SCL_DONE)
        else $error("init before completion high");

endmodule

// [verif/scl_mem_model.sv]
`timescale 1ns/1ps
// Serial configuration memory with an output-enable pin
module scl_mem_model (
    input  wire logic ref_clk,
    input  wire logic statusLine,
    input  wire logic doneLine,
    output logic      oeLow,
    output logic      serialClk,
    output logic      serialData
);
    initial begin
        oeLow      = 1'b0;
        serialClk  = 1'b0;
        serialData = 1'b0;
    end

    // Half of a 320 ns serial clock period
    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic send_image(input logic [7:0] bits, output logic ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 4000 && statusLine !== 1'b1; i++) half();
        half();
        half();
        for (i = 7; i >= 0; i--) begin
            if (statusLine !== 1'b1) begin
                serialData <= ~serialData;
                return;
            end
            // One target on a 1-bit stream
            serialData <= bits[i];
            half();
            serialClk <= 1'b1;
            half();
            serialClk <= 1'b0;
        end
        // Released data line shows no stale value
        serialData <= ~bits[0];
        for (i = 0; i < 64 && ok !== 1'b1; i++) begin
            half();
            half();
            ok = doneLine;
        end
        if (ok !== 1'b1) begin
            oeLow <= 1'b1;
            repeat (40) @(posedge ref_clk);
            oeLow <= 1'b0;
        end
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import scl_pkg::*;
    localparam int TO = 20;
    localparam int IC = 5;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       autoRestart = 1'b1;
    logic       configRequest_n = 1'b1;
    logic       chainIn_n = 1'b0;
    logic       startClk = 1'b0;
    logic       dataError = 1'b0;
    logic       statusOut, statusOe, confDoneOut, confDoneOe, chainOut_n;
    logic       userMode, ioTristate, oeLow, serialClk, serialData, ok;
    logic [7:0] image;
    // Wired lines with pull-ups: high unless someone drives low
    wire        statusLine = (statusOe ? statusOut : 1'b1) && !oeLow;
    wire        doneLine = confDoneOe ? confDoneOut : 1'b1;
    int         error_cnt = 0;
    int         n_checks = 0;

    always #20 ref_clk = ~ref_clk;

    scl_config_ctrl #(.IMAGE_BITS(8), .TIMEOUT_CYC(TO), .INIT_CYC(IC)) uut (
        .ref_clk(ref_clk), .rst(rst), .autoRestart(autoRestart),
        .configRequest_n(configRequest_n), .statusIn(statusLine),
        .statusOut(statusOut), .statusOe(statusOe), .confDoneIn(doneLine),
        .confDoneOut(confDoneOut), .confDoneOe(confDoneOe),
        .chain_enable_in_n(chainIn_n), .chain_enable_out_n(chainOut_n),
        .serial_config_clock(serialClk), .serial_config_data(serialData),
        .user_startup_clock(startClk), .dataError(dataError),
        .userMode(userMode), .ioTristate(ioTristate), .image(image));

    scl_mem_model mem (
        .ref_clk(ref_clk), .statusLine(statusLine), .doneLine(doneLine),
        .oeLow(oeLow), .serialClk(serialClk), .serialData(serialData));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Request pulse of 50 cycles, 2 us
    task automatic restart(input logic ar);
        autoRestart     <= ar;
        configRequest_n <= 1'b0;
        tick(50);
        configRequest_n <= 1'b1;
        tick(2);
    endtask

    task automatic startup_rises(input int n);
        repeat (n) begin
            @(posedge ref_clk) startClk <= 1'b1;
            tick(3);
            startClk <= 1'b0;
            tick(4);
        end
    endtask

    task automatic error_pulse();
        int n;
        tick(20);
        dataError <= 1'b1;
        tick(1);
        dataError <= 1'b0;
        tick(1);
        check(statusOe, 1'b1, "error status");
        for (n = 0; n < 200 && statusOe === 1'b1; n++) tick(1);
        check(n >= TO && n <= TO + 2, autoRestart, "timeout release");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_refused();
        chainIn_n <= 1'b1;
        mem.send_image(8'hA5, ok);
        check(image, 8'h00, "bits taken while disabled");
        check(ok, 1'b0, "done without load");
        chainIn_n <= 1'b0;
    endtask

    task automatic t_load_ok(input logic [7:0] img);
        mem.send_image(img, ok);
        check(ok, 1'b1, "completion");
        check(image, img, "image");
        check(chainOut_n, 1'b0, "chain enable out");
        startup_rises(IC - 1);
        check(userMode, 1'b0, "user mode early");
        startup_rises(1);
        check({userMode, ioTristate}, 2'b10, "user mode");
    endtask

    task automatic t_user_reconfig();
        configRequest_n <= 1'b0;
        tick(10);
        check({statusOut, confDoneOut}, 2'b00, "drive low only");
        check({statusOe, confDoneOe, ioTristate, userMode}, 4'hE,
              "request low");
        tick(40);
        check(statusOe, 1'b1, "held while low");
        configRequest_n <= 1'b1;
        tick(6);
        check(statusOe, 1'b0, "status released");
        t_load_ok(8'hC3);
    endtask

    // Restart during start-up, start-up clock kept running
    task automatic t_init_restart();
        startup_rises(2);
        fork
            restart(1'b1);
            startup_rises(10);
        join
        check(userMode, 1'b0, "restart in init");
        t_load_ok(8'h96);
    endtask

    task automatic t_error(input logic ar);
        restart(ar);
        fork
            mem.send_image(8'h81, ok);
            error_pulse();
        join
        check(ok, 1'b0, "load aborted");
        if (!ar) begin
            check(statusOe, 1'b1, "no auto release");
            restart(ar);
        end
        mem.send_image(8'h5A, ok);
        check({ok, image}, 9'h15A, "reload");
    endtask

    initial begin
        tick(4);
        rst <= 1'b0;
        t_refused();
        t_load_ok(8'h3C);
        t_user_reconfig();
        t_error(1'b1);
        t_error(1'b0);
        t_init_restart();
        finish_test();
    end

    initial begin
        #2000000;
        error_cnt++;
        finish_test();
    end
endmodule
